// ---- core/interline_ccd_timing_generator.sv ----
// Frame sequencer, APB registers and sensor clock outputs
// What this block does
// - Drive four clock groups: vertical, horizontal, reset, exposure control.
// - Each non-TDI frame starts with one photosite-to-storage vertical transfer.
// - Then a programmed number of one-row vertical transfers.
// - After each row not dumped in TDI mode, shift out a programmed number of pixels.
// - Exposure pulse may follow any chosen row, before its horizontal clocking.
// - TDI mode with a programmed number of integration stages.
// - Photosite 6 us, pedestal and delay 16 us, vertical 4 us minimum.
// - Pixel period 25 ns at full rate; reset pulse at least period/16.
// - Slower pixel rates such as 20 and 10 MHz also work.
// - Edge timings are adjustable through registers.
// - Bias settings programmable in 100 mV steps.
// - Full-rate horizontal clocking is 40 MHz.
// - Parameters, counts and mode loaded by the host over a port.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module interline_ccd_timing_generator
  import ccd_timing_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  output logic [3:0]                 v_clk_o,
  output logic                       v1_third_o,
  output logic                       h1_o,
  output logic                       h2_o,
  output logic                       last_horizontal_storage_phase_o,
  output logic                       high_gain_reset_pulse_o,
  output logic                       low_gain_reset_gate_o,
  output logic                       fast_line_dump_gate_o,
  output logic                       exposure_o,
  output logic                       frame_active_o,
  output logic [ccd_timing_pkg::BIAS_N*8-1:0] bias_codes_o
);
  import ccd_timing_pkg::*;

  frame_state_t state_q, state_d;

  // Live registers
  logic        cont_q, tdi_q, expo_en_q, start_q;
  logic [15:0] rows_q, pixels_q, tdi_stages_q, expo_row_q, expo_len_q;
  logic [15:0] photo_q, ped_q, delay_q, vxfer_q;
  logic [7:0]  pixper_q, rhgw_q;
  logic [7:0]  bias_q [BIAS_N];
  logic [15:0] frame_cnt_q;

  // Frame shadow copies
  logic        sh_tdi_q, sh_expo_en_q;
  logic [15:0] sh_rows_q, sh_pixels_q, sh_tdi_stages_q, sh_expo_row_q, sh_expo_len_q;
  logic [15:0] sh_photo_q, sh_ped_q, sh_delay_q, sh_vxfer_q;
  logic [7:0]  sh_pixper_q, sh_rhgw_q;

  logic [15:0] row_q;
  logic [1:0]  vstep_q;
  logic        tmr_start_q, pix_start_q;
  logic [15:0] tmr_len_q;
  logic        tmr_done, pix_done, pix_h1, pix_h2, pix_rst;
  logic        frame_go, last_row, expo_here, dump_row;

  // APB: access phase answered one cycle after it opens
  logic apb_acc, apb_hit;
  assign apb_acc = psel_i && penable_i && pready_o;
  always_comb begin
    apb_hit = 1'b1;
    unique case (paddr_i)
      REG_CTRL, REG_STATUS, REG_ROWS, REG_PIXELS, REG_TDI, REG_EXPO_ROW, REG_EXPO_LEN,
      REG_PHOTO, REG_PED, REG_DELAY, REG_VXFER, REG_PIXPER, REG_RHGW: apb_hit = 1'b1;
      default: apb_hit = (paddr_i >= REG_BIAS0) && (paddr_i < REG_BIAS0 + 8'(BIAS_N * 4))
                         && (paddr_i[1:0] == 2'b00);
    endcase
  end

  function automatic logic [31:0] read_reg(input logic [7:0] a);
    read_reg = 32'h0000_0000;
    unique case (a)
      REG_CTRL:     read_reg = {28'h0, expo_en_q, tdi_q, cont_q, 1'b0};
      REG_STATUS:   read_reg = {frame_cnt_q, 12'h0, 1'b0, 3'(state_q)} | {31'h0, frame_active_o};
      REG_ROWS:     read_reg = {16'h0, rows_q};
      REG_PIXELS:   read_reg = {16'h0, pixels_q};
      REG_TDI:      read_reg = {16'h0, tdi_stages_q};
      REG_EXPO_ROW: read_reg = {16'h0, expo_row_q};
      REG_EXPO_LEN: read_reg = {16'h0, expo_len_q};
      REG_PHOTO:    read_reg = {16'h0, photo_q};
      REG_PED:      read_reg = {16'h0, ped_q};
      REG_DELAY:    read_reg = {16'h0, delay_q};
      REG_VXFER:    read_reg = {16'h0, vxfer_q};
      REG_PIXPER:   read_reg = {24'h0, pixper_q};
      REG_RHGW:     read_reg = {24'h0, rhgw_q};
      default:      read_reg = (a >= REG_BIAS0) ? {24'h0, bias_q[3'((a - REG_BIAS0) >> 2)]}
                                                : 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !apb_hit;
      prdata_o  <= (psel_i && penable_i && !pready_o && !pwrite_i && apb_hit)
                 ? read_reg(paddr_i) : 32'h0000_0000;
    end
  end

  // Register writes from the host port
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_q <= 1'b0; cont_q <= 1'b0; tdi_q <= 1'b0; expo_en_q <= 1'b0;
      rows_q <= RST_ROWS; pixels_q <= RST_PIXELS; tdi_stages_q <= RST_TDI;
      expo_row_q <= 16'h0000; expo_len_q <= EXPO_MIN_CYC;
      photo_q <= PHOTO_MIN_CYC; ped_q <= PED_MIN_CYC;
      delay_q <= DELAY_MIN_CYC; vxfer_q <= VXFER_MIN_CYC;
      pixper_q <= RST_PIXPER; rhgw_q <= RST_RHGW;
      for (int i = 0; i < BIAS_N; i++) bias_q[i] <= RST_BIAS;
    end else begin
      start_q <= 1'b0;
      if (apb_acc && pwrite_i && !pslverr_o) begin
        unique case (paddr_i)
          REG_CTRL: begin
            start_q   <= pwdata_i[CTRL_START];
            cont_q    <= pwdata_i[CTRL_CONT];
            tdi_q     <= pwdata_i[CTRL_TDI];
            expo_en_q <= pwdata_i[CTRL_EXPO];
          end
          REG_ROWS:     rows_q       <= pwdata_i[15:0];
          REG_PIXELS:   pixels_q     <= pwdata_i[15:0];
          REG_TDI:      tdi_stages_q <= pwdata_i[15:0];
          REG_EXPO_ROW: expo_row_q   <= pwdata_i[15:0];
          REG_EXPO_LEN: expo_len_q   <= pwdata_i[15:0];
          REG_PHOTO:    photo_q      <= pwdata_i[15:0];
          REG_PED:      ped_q        <= pwdata_i[15:0];
          REG_DELAY:    delay_q      <= pwdata_i[15:0];
          REG_VXFER:    vxfer_q      <= pwdata_i[15:0];
          REG_PIXPER:   pixper_q     <= pwdata_i[7:0];
          REG_RHGW:     rhgw_q       <= pwdata_i[7:0];
          default: begin
            if (paddr_i >= REG_BIAS0)
              bias_q[3'((paddr_i - REG_BIAS0) >> 2)] <= pwdata_i[7:0];
          end
        endcase
      end
    end
  end

  // Shadow copy taken only when a frame begins
  assign frame_go = (state_q == ST_IDLE) && (start_q || cont_q) && (rows_q != 16'h0000);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_tdi_q <= 1'b0; sh_expo_en_q <= 1'b0;
      sh_rows_q <= RST_ROWS; sh_pixels_q <= RST_PIXELS; sh_tdi_stages_q <= RST_TDI;
      sh_expo_row_q <= 16'h0000; sh_expo_len_q <= EXPO_MIN_CYC;
      sh_photo_q <= PHOTO_MIN_CYC; sh_ped_q <= PED_MIN_CYC;
      sh_delay_q <= DELAY_MIN_CYC; sh_vxfer_q <= VXFER_MIN_CYC;
      sh_pixper_q <= RST_PIXPER; sh_rhgw_q <= RST_RHGW;
    end else if (frame_go) begin
      sh_tdi_q <= tdi_q; sh_expo_en_q <= expo_en_q;
      sh_rows_q <= rows_q; sh_pixels_q <= pixels_q; sh_tdi_stages_q <= tdi_stages_q;
      sh_expo_row_q <= expo_row_q;
      sh_expo_len_q <= at_least(expo_len_q, EXPO_MIN_CYC);
      sh_photo_q <= at_least(photo_q, PHOTO_MIN_CYC);
      sh_ped_q   <= at_least(ped_q, PED_MIN_CYC);
      sh_delay_q <= at_least(delay_q, DELAY_MIN_CYC);
      sh_vxfer_q <= at_least(vxfer_q, VXFER_MIN_CYC);
      sh_pixper_q <= pixper_q; sh_rhgw_q <= rhgw_q;
    end
  end

  assign last_row  = (row_q == sh_rows_q - 16'h0001);
  assign expo_here = sh_expo_en_q && (row_q == sh_expo_row_q);
  // In TDI the first stages-1 rows hold partial integration and are dumped
  assign dump_row  = sh_tdi_q && (row_q + 16'h0001 < sh_tdi_stages_q);

  // Frame sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (frame_go) state_d = tdi_q ? ST_VROW : ST_PED;
      ST_PED:   if (tmr_done) state_d = ST_PHOTO;
      ST_PHOTO: if (tmr_done) state_d = ST_DELAY;
      ST_DELAY: if (tmr_done) state_d = ST_VROW;
      ST_VROW: begin
        if (tmr_done && vstep_q == 2'd3)
          state_d = expo_here ? ST_EXPO : (dump_row ? ST_DUMP : ST_HROW);
      end
      ST_EXPO:  if (tmr_done) state_d = dump_row ? ST_DUMP : ST_HROW;
      ST_HROW, ST_DUMP: begin
        if ((state_q == ST_HROW) ? pix_done : tmr_done)
          state_d = last_row ? ST_IDLE : ST_VROW;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q     <= ST_IDLE;
      row_q       <= 16'h0000;
      vstep_q     <= 2'd0;
      tmr_start_q <= 1'b0;
      pix_start_q <= 1'b0;
      tmr_len_q   <= 16'h0000;
      frame_cnt_q <= 16'h0000;
    end else begin
      state_q     <= state_d;
      tmr_start_q <= 1'b0;
      pix_start_q <= 1'b0;
      if (state_q == ST_IDLE) begin
        row_q   <= 16'h0000;
        vstep_q <= 2'd0;
      end
      if (state_q == ST_VROW && tmr_done && vstep_q != 2'd3) begin
        vstep_q     <= vstep_q + 2'd1;
        tmr_start_q <= 1'b1;
        tmr_len_q   <= sh_vxfer_q;
      end
      if (state_d != state_q) begin
        tmr_start_q <= (state_d != ST_HROW) && (state_d != ST_IDLE);
        pix_start_q <= (state_d == ST_HROW);
        unique case (state_d)
          ST_PED:   tmr_len_q <= (state_q == ST_IDLE) ? at_least(ped_q, PED_MIN_CYC) : sh_ped_q;
          ST_PHOTO: tmr_len_q <= sh_photo_q;
          ST_DELAY: tmr_len_q <= sh_delay_q;
          ST_VROW:  tmr_len_q <= (state_q == ST_IDLE) ? at_least(vxfer_q, VXFER_MIN_CYC)
                                                      : sh_vxfer_q;
          ST_EXPO:  tmr_len_q <= sh_expo_len_q;
          ST_DUMP:  tmr_len_q <= sh_vxfer_q;
          default:  tmr_len_q <= tmr_len_q;
        endcase
        if (state_d == ST_VROW) vstep_q <= 2'd0;
        if (state_q == ST_HROW || state_q == ST_DUMP) row_q <= row_q + 16'h0001;
        if (state_d == ST_IDLE) frame_cnt_q <= frame_cnt_q + 16'h0001;
      end
    end
  end

  interval_timer u_timer (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (tmr_start_q),
    .len_i    (tmr_len_q),
    .done_o   (tmr_done)
  );

  pixel_clock_gen u_pixel (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .start_i     (pix_start_q),
    .count_i     (sh_pixels_q),
    .period_i    (sh_pixper_q),
    .rst_width_i (sh_rhgw_q),
    .h1_o        (pix_h1),
    .h2_o        (pix_h2),
    .rst_o       (pix_rst),
    .done_o      (pix_done)
  );

  // Four-phase vertical pattern per step
  function automatic logic [3:0] vpattern(input logic [1:0] s);
    unique case (s)
      2'd0: vpattern = 4'b0011;
      2'd1: vpattern = 4'b0110;
      2'd2: vpattern = 4'b1100;
      2'd3: vpattern = 4'b1001;
    endcase
  endfunction

  // Output flops; idle state drives all clocks inactive
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      v_clk_o <= 4'h0; v1_third_o <= 1'b0; h1_o <= 1'b0; h2_o <= 1'b0;
      last_horizontal_storage_phase_o <= 1'b0; high_gain_reset_pulse_o <= 1'b0;
      low_gain_reset_gate_o <= 1'b0; fast_line_dump_gate_o <= 1'b0;
      exposure_o <= 1'b0; frame_active_o <= 1'b0;
    end else begin
      v_clk_o <= (state_q == ST_VROW) ? vpattern(vstep_q)
               : (state_q inside {ST_PED, ST_PHOTO, ST_DELAY}) ? 4'b0001 : 4'h0;
      v1_third_o <= (state_q == ST_PHOTO);
      h1_o <= pix_h1;
      h2_o <= pix_h2;
      last_horizontal_storage_phase_o <= pix_h2;
      high_gain_reset_pulse_o <= pix_rst;
      low_gain_reset_gate_o   <= pix_rst;
      fast_line_dump_gate_o   <= (state_q == ST_DUMP);
      exposure_o     <= (state_q == ST_EXPO);
      frame_active_o <= (state_q != ST_IDLE);
    end
  end

  always_comb begin
    for (int i = 0; i < BIAS_N; i++) bias_codes_o[i*8 +: 8] = bias_q[i];
  end

  // Dwell counter for interval checks
  logic [15:0] dwell_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) dwell_q <= 16'h0000;
    else dwell_q <= (state_d != state_q) ? 16'h0000 : dwell_q + 16'h0001;
  end

  property p_idle_quiet;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_IDLE) [*3] |-> (v_clk_o == 4'h0) && !h1_o && !h2_o && !exposure_o
                                   && !fast_line_dump_gate_o && !high_gain_reset_pulse_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("clocks active in idle");

  property p_photo_min;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_PHOTO && state_d != ST_PHOTO) |-> (dwell_q + 16'h0001 >= PHOTO_MIN_CYC);
  endproperty
  a_photo_min: assert property (p_photo_min) else $error("photosite transfer too short");

  property p_ped_min;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q inside {ST_PED, ST_DELAY} && state_d != state_q)
        |-> (dwell_q + 16'h0001 >= PED_MIN_CYC);
  endproperty
  a_ped_min: assert property (p_ped_min) else $error("pedestal or delay too short");

  property p_vstep_min;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_VROW && tmr_done) |-> (dwell_q + 16'h0001 >= 16'(4) * VXFER_MIN_CYC)
                                           || (vstep_q != 2'd3);
  endproperty
  a_vstep_min: assert property (p_vstep_min) else $error("row transfer too short");

  property p_photo_once;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q == ST_PHOTO) ##1 (state_q != ST_PHOTO) |-> (state_q == ST_DELAY) ##1
        (state_q inside {ST_DELAY, ST_VROW});
  endproperty
  a_photo_once: assert property (p_photo_once) else $error("photosite transfer repeated");

  property p_shadow_hold;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q != ST_IDLE) |=> $stable(sh_rows_q) && $stable(sh_pixels_q) && $stable(sh_tdi_q);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("settings changed mid frame");

  property p_expo_after_row;
    @(posedge clk_i) disable iff (!resetn_i)
      $rose(exposure_o) |-> ($past(state_q, 2) == ST_VROW) && !h1_o;
  endproperty
  a_expo_after_row: assert property (p_expo_after_row) else $error("exposure misplaced");

  property p_h_in_row;
    @(posedge clk_i) disable iff (!resetn_i)
      (h1_o || h2_o) |-> ($past(state_q, 2) == ST_HROW);
  endproperty
  a_h_in_row: assert property (p_h_in_row) else $error("horizontal clock outside row readout");

  property p_rows_count;
    @(posedge clk_i) disable iff (!resetn_i)
      (state_q inside {ST_HROW, ST_DUMP} && state_d == ST_IDLE) |-> (row_q + 16'h0001 == sh_rows_q);
  endproperty
  a_rows_count: assert property (p_rows_count) else $error("wrong number of rows");

  c_frame_done: cover property (@(posedge clk_i) disable iff (!resetn_i)
    $fell(frame_active_o));
  c_exposure:   cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(exposure_o));
  c_tdi_dump:   cover property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(fast_line_dump_gate_o));
endmodule

// ---- core/interval_timer.sv ----
// One-shot interval counter: done pulse after len cycles
`timescale 1ns/10ps
module interval_timer
  import ccd_timing_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [15:0] len_i,
  output logic             done_o
);
  logic [15:0] cnt_q;
  logic        run_q;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q  <= 16'h0000;
      run_q  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= (len_i == 16'h0000) ? 16'h0000 : len_i - 16'h0001;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= 16'h0001) begin
          run_q  <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end
endmodule

// ---- core/pixel_clock_gen.sv ----
// Horizontal shift and output reset clocks for one row of pixels
`timescale 1ns/10ps
module pixel_clock_gen
  import ccd_timing_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [15:0] count_i,
  input  wire logic [7:0]  period_i,
  input  wire logic [7:0]  rst_width_i,
  output logic             h1_o,
  output logic             h2_o,
  output logic             rst_o,
  output logic             done_o
);
  logic [7:0]  phase_q;
  logic [15:0] left_q;
  logic        run_q;
  logic [7:0]  per;
  logic [7:0]  rhgw;
  logic [7:0]  rst_min;

  // Pixel period never below full rate; reset pulse at least period/16
  assign per  = (period_i < PIXEL_MIN_CYC) ? PIXEL_MIN_CYC : period_i;
  assign rst_min = 8'((9'(per) + 9'(RST_DIVISOR - 1)) / 9'(RST_DIVISOR));
  assign rhgw = (rst_width_i < rst_min) ? rst_min : rst_width_i;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= 8'h00;
      left_q  <= 16'h0000;
      run_q   <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        phase_q <= 8'h00;
        left_q  <= count_i;
        run_q   <= (count_i != 16'h0000);
        done_o  <= (count_i == 16'h0000);
      end else if (run_q) begin
        if (phase_q == per - 8'h01) begin
          phase_q <= 8'h00;
          left_q  <= left_q - 16'h0001;
          if (left_q == 16'h0001) begin
            run_q  <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          phase_q <= phase_q + 8'h01;
        end
      end
    end
  end

  // Two-phase shift, reset pulse at the start of each pixel
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      h1_o  <= 1'b0;
      h2_o  <= 1'b0;
      rst_o <= 1'b0;
    end else begin
      h1_o  <= run_q && !start_i && (phase_q < (per >> 1));
      h2_o  <= run_q && !start_i && (phase_q >= (per >> 1));
      rst_o <= run_q && !start_i && (phase_q < rhgw);
    end
  end

  logic [7:0] rst_len_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) rst_len_q <= 8'h00;
    else rst_len_q <= rst_o ? rst_len_q + 8'h01 : 8'h00;
  end

  property p_rst_width;
    @(posedge clk_i) disable iff (!resetn_i)
      $fell(rst_o) |-> (16'(rst_len_q) * 16'(RST_DIVISOR) >= 16'(per));
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse shorter than period/16");
endmodule

// ---- shared/ccd_timing_pkg.sv ----
// Constants, register map and state type for the interline sensor timing generator
package ccd_timing_pkg;
  // Clock and minimum timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int PHOTO_MIN_NS  = 6000;   // photosite transfer
  localparam int PED_MIN_NS    = 16000;  // third phase pedestal
  localparam int DELAY_MIN_NS  = 16000;  // third phase delay
  localparam int VXFER_MIN_NS  = 4000;   // vertical transfer
  localparam int EXPO_MIN_NS   = 2000;   // substrate shutter pulse
  localparam int PIXEL_MIN_NS  = 25;     // full rate pixel period
  localparam int RST_DIVISOR   = 16;     // reset pulse >= period / 16

  localparam logic [15:0] PHOTO_MIN_CYC = 16'((PHOTO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PED_MIN_CYC   = 16'((PED_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DELAY_MIN_CYC = 16'((DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] VXFER_MIN_CYC = 16'((VXFER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] EXPO_MIN_CYC  = 16'((EXPO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  PIXEL_MIN_CYC = 8'((PIXEL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_ROWS     = 8'h08;
  localparam logic [7:0] REG_PIXELS   = 8'h0c;
  localparam logic [7:0] REG_TDI      = 8'h10;
  localparam logic [7:0] REG_EXPO_ROW = 8'h14;
  localparam logic [7:0] REG_EXPO_LEN = 8'h18;
  localparam logic [7:0] REG_PHOTO    = 8'h1c;
  localparam logic [7:0] REG_PED      = 8'h20;
  localparam logic [7:0] REG_DELAY    = 8'h24;
  localparam logic [7:0] REG_VXFER    = 8'h28;
  localparam logic [7:0] REG_PIXPER   = 8'h2c;
  localparam logic [7:0] REG_RHGW     = 8'h30;
  localparam logic [7:0] REG_BIAS0    = 8'h40;
  localparam int         BIAS_N       = 8;

  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_CONT  = 1;
  localparam int CTRL_TDI   = 2;
  localparam int CTRL_EXPO  = 3;

  // Reset values
  localparam logic [15:0] RST_ROWS   = 16'h0010;
  localparam logic [15:0] RST_PIXELS = 16'h0020;
  localparam logic [15:0] RST_TDI    = 16'h0004;
  localparam logic [7:0]  RST_PIXPER = 8'h05;
  localparam logic [7:0]  RST_RHGW   = 8'h01;
  localparam logic [7:0]  RST_BIAS   = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PED, ST_PHOTO, ST_DELAY, ST_VROW, ST_EXPO, ST_HROW, ST_DUMP
  } frame_state_t;

  function automatic logic [15:0] at_least(input logic [15:0] v, input logic [15:0] lo);
    at_least = (v < lo) ? lo : v;
  endfunction
endpackage

// ---- verif/sensor_model.sv ----
// Sensor stand-in that counts the clock events it receives
`timescale 1ns/10ps
module sensor_model (
  input  wire logic             clk_i,
  input  wire logic             clr_i,
  input  wire logic [3:0]       v_clk_i,
  input  wire logic             v1_third_i,
  input  wire logic             h1_i,
  input  wire logic             dump_i,
  input  wire logic             exposure_i,
  output logic      [4:0][15:0] cnt_o
);
  logic      [7:0] last_q;
  wire logic [7:0] now = {v_clk_i, v1_third_i, h1_i, dump_i, exposure_i};

  // Photosite moves, rows, pixels, exposures, dumps
  always_ff @(posedge clk_i) begin
    last_q <= now;
    if (clr_i) begin
      cnt_o <= '0;
    end else begin
      cnt_o[0] <= cnt_o[0] + 16'(now[3] & ~last_q[3]);
      cnt_o[1] <= cnt_o[1] + 16'(now[7:4] == 4'h9 && last_q[7:4] != 4'h9);
      cnt_o[2] <= cnt_o[2] + 16'(now[2] & ~last_q[2]);
      cnt_o[3] <= cnt_o[3] + 16'(now[0] & ~last_q[0]);
      cnt_o[4] <= cnt_o[4] + 16'(now[1] & ~last_q[1]);
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench: register traffic, frame runs and event counts
`timescale 1ns/10ps
module tb;
  import ccd_timing_pkg::*;
  logic             clk_i, resetn_i, psel, pen, pwr, clr;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, lfsr, npix;
  logic [33:0]      notes[$];
  logic [4:0][15:0] cnt;
  int               err_count, cmp_count, cyc;
  wire logic        pready, pslverr, h1, h2, expo, act, dump, v1t, hg, lg, lhs;
  wire logic [3:0]  pin = {h2, hg, lg, lhs};
  logic [3:0]       pin_q;
  logic [3:0][15:0] pin_cnt;
  wire logic [31:0] prdata;
  wire logic [3:0]  vclk;
  wire logic [63:0] bias;

  interline_ccd_timing_generator dut (.clk_i, .resetn_i, .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .v_clk_o(vclk), .v1_third_o(v1t), .h1_o(h1), .h2_o(h2),
    .last_horizontal_storage_phase_o(lhs),
    .high_gain_reset_pulse_o(hg), .low_gain_reset_gate_o(lg),
    .fast_line_dump_gate_o(dump), .exposure_o(expo), .frame_active_o(act), .bias_codes_o(bias));
  sensor_model partner (.clk_i, .clr_i(clr), .v_clk_i(vclk), .v1_third_i(v1t), .h1_i(h1),
    .dump_i(dump), .exposure_i(expo), .cnt_o(cnt));

  // Rising edges of h2, both reset pulses and last storage phase
  always @(posedge clk_i) begin
    pin_q <= pin;
    for (int j = 0; j < 4; j++) pin_cnt[j] <= clr ? 16'h0 : pin_cnt[j] + 16'(pin[j] & ~pin_q[j]);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Note holds {is read, error, data}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk_i);
    notes.push_back({~w, e});
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Starts a frame, changes rows mid-frame, compares event counts after it
  task automatic frame(input logic [31:0] ctrl, input logic [79:0] e);
    clr <= 1'b1;
    apb(1'b1, REG_CTRL, ctrl, 33'h0);
    clr <= 1'b0;
    do @(posedge clk_i); while (act !== 1'b1);
    apb(1'b1, REG_ROWS, 32'd3, 33'h0);
    do @(posedge clk_i); while (act !== 1'b0);
    @(posedge clk_i);
    for (int i = 0; i < 5; i++) chk(32'(cnt[i]), 32'(e[16*i+:16]));
    for (int j = 0; j < 4; j++) chk(32'(pin_cnt[j]), 32'(e[47:32]));
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      err_count++;
      complete_run();
    end
    if (psel && pen && pready === 1'b1) begin
      chk({31'h0, pslverr}, {31'h0, notes[0][32]});
      if (notes[0][33]) chk(prdata, notes[0][31:0]);
      void'(notes.pop_front());
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    {resetn_i, psel, pen, pwr, clr} = 5'b00001;
    paddr = '0;
    pwdata = '0;
    cyc = 0;
    err_count = 0;
    cmp_count = 0;
    lfsr = 32'd80305;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    chk({22'h0, vclk, h1, h2, expo, act, dump, v1t}, 32'h0);
    apb(1'b0, REG_ROWS, 0, {1'b0, 32'(RST_ROWS)});
    apb(1'b0, REG_PIXPER, 0, {1'b0, 32'(RST_PIXPER)});
    apb(1'b0, 8'hfc, 0, {1'b1, 32'h0});
    apb(1'b1, 8'h80, lfsr, {1'b1, 32'h0});
    for (int k = 0; k < BIAS_N; k++) begin
      lfsr = step(lfsr);
      apb(1'b1, REG_BIAS0 + 8'(4 * k), {24'h0, lfsr[7:0]}, 33'h0);
      apb(1'b0, REG_BIAS0 + 8'(4 * k), 0, {1'b0, 24'h0, lfsr[7:0]});
      chk({24'h0, bias[8*k+:8]}, {24'h0, lfsr[7:0]});
    end
    // Zero timings are raised to the minimum intervals
    for (int a = 7; a < 11; a++) apb(1'b1, 8'(4 * a), 0, 33'h0);
    apb(1'b1, REG_EXPO_LEN, 0, 33'h0);
    lfsr = step(lfsr);
    npix = 32'd1 + 32'(lfsr[1:0]);
    apb(1'b1, REG_PIXELS, npix, 33'h0);
    apb(1'b1, REG_ROWS, 2, 33'h0);
    apb(1'b1, REG_EXPO_ROW, 1, 33'h0);
    apb(1'b1, REG_TDI, 2, 33'h0);
    frame(32'h9, {16'd0, 16'd1, 16'(2 * npix), 16'd2, 16'd1});
    apb(1'b0, REG_STATUS, 0, {1'b0, 32'h0001_0000});
    apb(1'b1, REG_PIXPER, 10, 33'h0);
    frame(32'h5, {16'd1, 16'd0, 16'(2 * npix), 16'd3, 16'd0});
    apb(1'b0, REG_STATUS, 0, {1'b0, 32'h0002_0000});
    complete_run();
  end
endmodule
